// ### src/utmi_phy_end.sv
// Transceiver end of the parallel link: transmit serializer and receive framing.
// Assumes a receive chain on the same clock reports sync, bytes and end of packet,
// and that the line driver and disconnect comparator sit outside this module.
`timescale 1ns/1ns
`include "utmi_consts.svh"

module utmi_phy_end
	import utmi_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Parallel link
	utmi_if.phy pif,
	// Receive chain
	input wire logic i_rx_sync_det,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_rx_byte_load,
	input wire logic i_rx_eop_det,
	// Disconnect comparator, asynchronous
	input wire logic i_disc_comp,
	// Serial line drive
	output logic o_tx_dat,
	output logic o_tx_se0,
	output logic o_tx_oe
);

	tx_state_t state_ff, nxt_state;
	logic [6:0] tmr_ff, nxt_tmr;
	logic [5:0] bit_ff, nxt_bit;
	logic [7:0] sh_ff, nxt_sh;
	logic [7:0] hold_ff, nxt_hold;
	logic hold_v_ff, nxt_hold_v;
	logic [2:0] ones_ff, nxt_ones;
	logic lvl_ff, nxt_lvl;
	logic se0_ff, nxt_se0;
	logic oe_ff, nxt_oe;
	logic txready_ff, nxt_txready;
	logic sof_ff, nxt_sof;
	logic ka_ff, nxt_ka;
	logic [1:0] pre_ff, nxt_pre;
	logic hostdisc_ff, nxt_hostdisc;
	logic disc_s1_ff, disc_s2_ff;
	logic rxactive_ff, rxvalid_ff, dq_oe_ff, pclk_ff;
	logic [7:0] rxdata_ff;
	logic tick;
	logic fetch_ok;
	logic [6:0] per;

	// Bit period in cycles for the current state and transceiver select
	function automatic logic [6:0] bit_period(input xcvr_sel_t sel, input logic [1:0] pre, input tx_state_t st);
		logic [6:0] p;
		p = 7'(`HS_BIT_CYC);
		if (st == TX_RES_SE0 || sel == SEL_LS || (sel == SEL_FS_PRE && pre == 2'h0))
			p = 7'(`LS_BIT_CYC);
		else if (st == TX_RES_J || sel == SEL_FS || sel == SEL_FS_PRE)
			p = 7'(`FS_BIT_CYC);
		return p;
	endfunction

	// Transmit sequencer next state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_bit = bit_ff;
		nxt_sh = sh_ff;
		nxt_hold = hold_ff;
		nxt_hold_v = hold_v_ff;
		nxt_ones = ones_ff;
		nxt_lvl = lvl_ff;
		nxt_se0 = se0_ff;
		nxt_oe = oe_ff;
		nxt_sof = sof_ff;
		nxt_ka = ka_ff;
		nxt_pre = pre_ff;
		nxt_hostdisc = hostdisc_ff;
		nxt_txready = 1'b0;
		per = bit_period(pif.xcvr_sel, pre_ff, state_ff);
		tick = (tmr_ff == 7'h00);
		nxt_tmr = tick ? per - 7'h01 : tmr_ff - 7'h01;
		// One fetch window per byte time, none once TXVALID has dropped
		fetch_ok = (state_ff == TX_IDLE && pif.op_mode != OP_NOSTUFF) ||
			((state_ff == TX_SYNC || state_ff == TX_DATA) && bit_ff == 6'h00);
		if (fetch_ok && pif.txvalid && !hold_v_ff && !txready_ff)
			nxt_txready = 1'b1;
		if (txready_ff && pif.txvalid)
		begin
			nxt_hold = pif.data;
			nxt_hold_v = 1'b1;
		end
		case (state_ff)
			TX_IDLE:
			begin
				nxt_oe = 1'b0;
				nxt_se0 = 1'b0;
				nxt_lvl = 1'b1;
				nxt_tmr = per - 7'h01;
				if (pif.txvalid && pif.op_mode == OP_NOSTUFF)
					nxt_state = TX_RES_K;
				else if (hold_v_ff)
				begin
					nxt_sof = (hold_ff == `PID_SOF);
					nxt_ka = (hold_ff == `PID_SOF) && (pif.xcvr_sel == SEL_LS);
					nxt_pre = (pif.xcvr_sel == SEL_FS_PRE) ? 2'h2 : 2'h0;
					nxt_oe = !((hold_ff == `PID_SOF) && (pif.xcvr_sel == SEL_LS));
					nxt_sh = `SYNC_BYTE;
					nxt_bit = 6'h00;
					nxt_ones = 3'h0;
					nxt_state = TX_SYNC;
				end
			end
			TX_SYNC, TX_DATA:
			begin
				if (tick && ones_ff == `STUFF_RUN)
				begin
					nxt_lvl = !lvl_ff; // Stuffed zero toggles the line
					nxt_ones = 3'h0;
				end
				else if (tick)
				begin
					nxt_lvl = sh_ff[0] ? lvl_ff : !lvl_ff; // NRZI
					nxt_ones = sh_ff[0] ? ones_ff + 3'h1 : 3'h0;
					nxt_sh = {1'b0, sh_ff[7:1]};
					nxt_bit = bit_ff + 6'h01;
					if (bit_ff == `LAST_BIT_OF_BYTE)
					begin
						nxt_bit = 6'h00;
						nxt_state = TX_DATA;
						if (pre_ff == 2'h2)
						begin
							nxt_sh = `PID_PRE; // Full-speed preamble PID
							nxt_pre = 2'h1;
						end
						else if (pre_ff == 2'h1)
						begin
							nxt_sh = `SYNC_BYTE; // Then the packet at low speed
							nxt_pre = 2'h0;
							nxt_state = TX_SYNC;
						end
						else if (hold_v_ff)
						begin
							nxt_sh = hold_ff;
							nxt_hold_v = 1'b0;
						end
						else
							nxt_state = TX_EOP;
					end
				end
			end
			TX_EOP:
			begin
				if (tick)
				begin
					nxt_bit = bit_ff + 6'h01;
					if (pif.xcvr_sel == SEL_HS)
					begin
						nxt_lvl = (bit_ff == 6'h00) ? !lvl_ff : lvl_ff;
						if (pif.host_mode && sof_ff && bit_ff == `DISC_SAMPLE_BIT)
							nxt_hostdisc = disc_s2_ff;
						if (bit_ff == (sof_ff ? `HS_SOF_EOP_BITS : `HS_EOP_BITS) - 6'h01)
							nxt_state = TX_IDLE;
					end
					else
					begin
						// Keep-alive is this SE0-SE0-J end on an otherwise idle line
						nxt_oe = 1'b1;
						nxt_se0 = (bit_ff < `FS_EOP_SE0_BITS);
						nxt_lvl = 1'b1;
						if (bit_ff == `FS_EOP_BITS)
							nxt_state = TX_IDLE;
					end
				end
			end
			TX_RES_K:
			begin
				nxt_oe = 1'b1;
				nxt_lvl = 1'b0;
				nxt_se0 = 1'b0;
				nxt_bit = 6'h00;
				// SE0 must start on a full LS bit, whatever rate the timer ran at before
				nxt_tmr = 7'(`LS_BIT_CYC) - 7'h01;
				if (!pif.txvalid)
				begin
					nxt_state = pif.host_mode ? TX_RES_SE0 : TX_IDLE;
					nxt_se0 = pif.host_mode; // SE0 starts with the state, not a cycle late
				end
			end
			TX_RES_SE0:
			begin
				nxt_se0 = 1'b1;
				if (tick)
				begin
					nxt_bit = bit_ff + 6'h01;
					if (bit_ff == `RESUME_SE0_BITS - 6'h01)
					begin
						nxt_se0 = 1'b0; // Two LS bit times of SE0, then FS J
						nxt_lvl = 1'b1;
						nxt_tmr = 7'(`FS_BIT_CYC) - 7'h01; // J lasts one FS bit, not an LS one
						nxt_state = TX_RES_J;
					end
				end
			end
			TX_RES_J:
			begin
				if (tick)
					nxt_state = TX_IDLE;
			end
			default:
				nxt_state = TX_IDLE;
		endcase
	end

	// Transmit sequencer registers
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_ff <= TX_IDLE;
			tmr_ff <= 7'h00;
			bit_ff <= 6'h00;
			sh_ff <= 8'h00;
			hold_ff <= 8'h00;
			hold_v_ff <= 1'b0;
			ones_ff <= 3'h0;
			lvl_ff <= 1'b1;
			se0_ff <= 1'b0;
			oe_ff <= 1'b0;
			txready_ff <= 1'b0;
			sof_ff <= 1'b0;
			ka_ff <= 1'b0;
			pre_ff <= 2'h0;
			hostdisc_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			bit_ff <= nxt_bit;
			sh_ff <= nxt_sh;
			hold_ff <= nxt_hold;
			hold_v_ff <= nxt_hold_v;
			ones_ff <= nxt_ones;
			lvl_ff <= nxt_lvl;
			se0_ff <= nxt_se0;
			oe_ff <= nxt_oe;
			txready_ff <= nxt_txready;
			sof_ff <= nxt_sof;
			ka_ff <= nxt_ka;
			pre_ff <= nxt_pre;
			hostdisc_ff <= nxt_hostdisc;
		end
	end

	// Receive framing, bus direction, comparator synchroniser and parallel clock
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rxactive_ff <= 1'b0;
			rxvalid_ff <= 1'b0;
			rxdata_ff <= 8'h00;
			dq_oe_ff <= 1'b0;
			disc_s1_ff <= 1'b0;
			disc_s2_ff <= 1'b0;
			pclk_ff <= 1'b0;
		end
		else
		begin
			rxactive_ff <= i_rx_eop_det ? 1'b0 : (i_rx_sync_det ? 1'b1 : rxactive_ff);
			rxvalid_ff <= rxactive_ff && i_rx_byte_load && !i_rx_eop_det;
			rxdata_ff <= i_rx_byte_load ? i_rx_byte : rxdata_ff;
			dq_oe_ff <= !pif.txvalid;
			disc_s1_ff <= i_disc_comp;
			disc_s2_ff <= disc_s1_ff;
			pclk_ff <= !pclk_ff;
		end
	end

	// Outputs straight from flops
	assign pif.parallel_if_clock = pclk_ff;
	assign pif.txready = txready_ff;
	assign pif.rxactive = rxactive_ff;
	assign pif.rxvalid = rxvalid_ff;
	assign pif.hostdisc = hostdisc_ff;
	assign pif.phy_dq_o = rxdata_ff;
	assign pif.phy_dq_oe = dq_oe_ff;
	assign o_tx_dat = lvl_ff;
	assign o_tx_se0 = se0_ff;
	assign o_tx_oe = oe_ff;

endmodule

// ### src/utmi_consts.svh
// Timing counts, bit patterns and field values shared by both ends of the parallel link.
// Assumes the logic clock i_mclk runs at 100 MHz.
`ifndef UTMI_CONSTS_SVH
`define UTMI_CONSTS_SVH

// Clock and serial bit periods in picoseconds
`define CLK_PERIOD_PS 10000
`define HS_BIT_PS 2083
`define FS_BIT_PS 83333
`define LS_BIT_PS 666667

// Bit periods in clock cycles, rounded down, never below one
`define HS_BIT_CYC ((`HS_BIT_PS / `CLK_PERIOD_PS) > 0 ? (`HS_BIT_PS / `CLK_PERIOD_PS) : 1)
`define FS_BIT_CYC ((`FS_BIT_PS / `CLK_PERIOD_PS) > 0 ? (`FS_BIT_PS / `CLK_PERIOD_PS) : 1)
`define LS_BIT_CYC ((`LS_BIT_PS / `CLK_PERIOD_PS) > 0 ? (`LS_BIT_PS / `CLK_PERIOD_PS) : 1)

// Serial patterns, sent least significant bit first
`define SYNC_BYTE 8'h80
`define PID_SOF 8'ha5
`define PID_PRE 8'h3c

// Bit stuffing run length and end-of-packet lengths in bits
`define STUFF_RUN 3'h6
`define LAST_BIT_OF_BYTE 6'h07
`define HS_EOP_BITS 6'h08
`define HS_SOF_EOP_BITS 6'h28
`define DISC_SAMPLE_BIT 6'h1f
`define FS_EOP_SE0_BITS 6'h02
`define FS_EOP_BITS 6'h03
`define RESUME_SE0_BITS 6'h02

// Idle cycles the link leaves between two packets
`define IPG_CYC 8'h10

`endif

// ### src/utmi_pkg.sv
// Types shared by both ends of the parallel link.
// Assumes utmi_consts.svh holds all numeric constants.
package utmi_pkg;

	// Transceiver select: speed of the data and handshake timing
	typedef enum logic [1:0] {
		SEL_HS = 2'h0,
		SEL_FS = 2'h1,
		SEL_LS = 2'h2,
		SEL_FS_PRE = 2'h3
	} xcvr_sel_t;

	// Operating mode of the transmit path
	typedef enum logic [1:0] {
		OP_NORMAL = 2'h0,
		OP_NODRIVE = 2'h1,
		OP_NOSTUFF = 2'h2,
		OP_RSVD = 2'h3
	} op_mode_t;

	// Transmit sequencer states, one-hot
	typedef enum logic [6:0] {
		TX_IDLE = 7'h01,
		TX_SYNC = 7'h02,
		TX_DATA = 7'h04,
		TX_EOP = 7'h08,
		TX_RES_K = 7'h10,
		TX_RES_SE0 = 7'h20,
		TX_RES_J = 7'h40
	} tx_state_t;

endpackage

// ### src/utmi_if.sv
// Parallel link between the transceiver end and the link controller end.
// Assumes both ends run on the same clock; the shared data bus level is resolved here.
`timescale 1ns/1ns
interface utmi_if;
	import utmi_pkg::*;

	// Clock and handshakes
	logic parallel_if_clock;
	logic txvalid;
	logic txready;
	logic rxactive;
	logic rxvalid;
	logic hostdisc;
	// Mode selects from the link
	xcvr_sel_t xcvr_sel;
	op_mode_t op_mode;
	logic host_mode;
	// Two-way data bus, one driver per end
	logic [7:0] phy_dq_o;
	logic phy_dq_oe;
	logic [7:0] link_dq_o;
	logic link_dq_oe;
	logic [7:0] data;

	// Bus level: the phy end's driver when enabled, else the link end's, zero when neither is
	assign data = phy_dq_oe ? phy_dq_o : (link_dq_oe ? link_dq_o : 8'h00);

	modport phy (
		output parallel_if_clock, txready, rxactive, rxvalid, hostdisc, phy_dq_o, phy_dq_oe,
		input txvalid, xcvr_sel, op_mode, host_mode, data
	);

	modport link (
		output txvalid, xcvr_sel, op_mode, host_mode, link_dq_o, link_dq_oe,
		input parallel_if_clock, txready, rxactive, rxvalid, hostdisc, data
	);
endinterface

// ### src/utmi_link_end.sv
// Link controller end: feeds transmit bytes and collects received bytes over the parallel link.
// Assumes the user side holds a byte valid until o_tx_byte_taken and supplies the next byte
// within one byte time of the previous one being taken.
`timescale 1ns/1ns
`include "utmi_consts.svh"
module utmi_link_end
	import utmi_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Parallel link
	utmi_if.link pif,
	// Transmit user side
	input wire logic [7:0] i_tx_byte,
	input wire logic i_tx_byte_valid,
	input wire logic i_tx_byte_last,
	output logic o_tx_byte_taken,
	// Mode selects
	input wire xcvr_sel_t i_xcvr_sel,
	input wire op_mode_t i_op_mode,
	input wire logic i_host_mode,
	// Receive user side
	output logic [7:0] o_rx_byte,
	output logic o_rx_byte_valid,
	output logic o_rx_active,
	output logic o_hostdisc
);

	logic txvalid_ff, nxt_txvalid;
	logic [7:0] dq_ff, nxt_dq;
	logic last_ff, nxt_last;
	logic need_ff, nxt_need;
	logic taken_ff, nxt_taken;
	logic [7:0] gap_ff, nxt_gap;
	xcvr_sel_t sel_ff;
	op_mode_t op_ff;
	logic host_ff;
	logic [7:0] rx_byte_ff;
	logic rx_valid_ff;
	logic rx_active_ff;
	logic hostdisc_ff;

	// Transmit side: start, byte advance and packet end
	always_comb
	begin
		nxt_txvalid = txvalid_ff;
		nxt_dq = dq_ff;
		nxt_last = last_ff;
		nxt_need = need_ff;
		nxt_taken = 1'b0;
		nxt_gap = (gap_ff != 8'h00) ? gap_ff - 8'h01 : gap_ff;
		if (!txvalid_ff)
		begin
			// PID goes on link_dq_o in the same cycle TXVALID rises
			if (gap_ff == 8'h00 && i_tx_byte_valid && !taken_ff)
			begin
				nxt_txvalid = 1'b1;
				nxt_dq = i_tx_byte;
				nxt_last = i_tx_byte_last;
				nxt_taken = 1'b1;
			end
		end
		else if (op_ff == OP_NOSTUFF && !i_tx_byte_valid)
		begin
			// Resume K gets no ready; the user ends it by dropping valid
			nxt_txvalid = 1'b0;
			nxt_gap = `IPG_CYC;
		end
		else if (pif.txready) // Byte consumed at this rising edge
		begin
			if (last_ff)
			begin
				nxt_txvalid = 1'b0;
				nxt_gap = `IPG_CYC;
			end
			else
				nxt_need = 1'b1;
		end
		else if (need_ff && i_tx_byte_valid && !taken_ff)
		begin
			// Next byte stays on the bus until consumed
			nxt_dq = i_tx_byte;
			nxt_last = i_tx_byte_last;
			nxt_need = 1'b0;
			nxt_taken = 1'b1;
		end
	end

	// Transmit registers
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			txvalid_ff <= 1'b0;
			dq_ff <= 8'h00;
			last_ff <= 1'b0;
			need_ff <= 1'b0;
			taken_ff <= 1'b0;
			gap_ff <= 8'h00;
		end
		else
		begin
			txvalid_ff <= nxt_txvalid;
			dq_ff <= nxt_dq;
			last_ff <= nxt_last;
			need_ff <= nxt_need;
			taken_ff <= nxt_taken;
			gap_ff <= nxt_gap;
		end
	end

	// Receive capture, status and mode registers
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rx_byte_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
			rx_active_ff <= 1'b0;
			hostdisc_ff <= 1'b0;
			sel_ff <= SEL_FS;
			op_ff <= OP_NORMAL;
			host_ff <= 1'b0;
		end
		else
		begin
			rx_byte_ff <= (pif.rxactive && pif.rxvalid) ? pif.data : rx_byte_ff;
			rx_valid_ff <= pif.rxactive && pif.rxvalid && !pif.txvalid;
			rx_active_ff <= pif.rxactive;
			hostdisc_ff <= pif.hostdisc;
			sel_ff <= i_xcvr_sel;
			op_ff <= i_op_mode;
			host_ff <= i_host_mode;
		end
	end

	// Link drives the data bus only while transmitting
	assign pif.txvalid = txvalid_ff;
	assign pif.link_dq_o = dq_ff;
	assign pif.link_dq_oe = txvalid_ff;
	assign pif.xcvr_sel = sel_ff;
	assign pif.op_mode = op_ff;
	assign pif.host_mode = host_ff;
	assign o_tx_byte_taken = taken_ff;
	assign o_rx_byte = rx_byte_ff;
	assign o_rx_byte_valid = rx_valid_ff;
	assign o_rx_active = rx_active_ff;
	assign o_hostdisc = hostdisc_ff;

endmodule

// ### tb/utmi_monitor.sv
// Checker for the parallel link between the two ends.
// Assumes all signals are taken from the interface and sampled on i_mclk.
`timescale 1ns/1ns
module utmi_monitor
	import utmi_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Interface signals
	input wire logic parallel_if_clock,
	input wire logic txvalid,
	input wire logic txready,
	input wire logic rxactive,
	input wire logic rxvalid,
	input wire logic phy_dq_oe,
	input wire xcvr_sel_t xcvr_sel,
	input wire op_mode_t op_mode
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	// Parallel clock marker never stalls
	property p_clk_runs;
		$past(i_resetn) |-> parallel_if_clock != $past(parallel_if_clock);
	endproperty
	a_clk_runs: assert property (p_clk_runs)
		else $error("parallel clock stalled");

	// Bus turns toward the link while no transmit is going on
	property p_bus_rx;
		$past(i_resetn) && !txvalid && !$past(txvalid) |-> phy_dq_oe;
	endproperty
	a_bus_rx: assert property (p_bus_rx)
		else $error("bus not driven by phy while idle");

	// A byte is consumed only while the link owns the bus
	property p_bus_tx;
		txvalid && txready |-> !phy_dq_oe;
	endproperty
	a_bus_tx: assert property (p_bus_tx)
		else $error("phy drives bus during consume");

	// Ready is a single cycle pulse
	property p_ready_pulse;
		txready |=> !txready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("txready longer than one cycle");

	// Full speed byte times are long; no second pulse soon after one
	property p_fs_gap;
		txready && xcvr_sel == SEL_FS |=> !txready [*8];
	endproperty
	a_fs_gap: assert property (p_fs_gap)
		else $error("txready pulses too close in full speed");

	// No ready once the link has ended the packet
	property p_no_ready_idle;
		!txvalid |-> !txready;
	endproperty
	a_no_ready_idle: assert property (p_no_ready_idle)
		else $error("txready without txvalid");

	// A new packet is answered on the next cycle
	property p_first_ready;
		$rose(txvalid) && op_mode != OP_NOSTUFF |=> txready;
	endproperty
	a_first_ready: assert property (p_first_ready)
		else $error("no txready after txvalid rose");

	// Received bytes only inside a framed packet, with bus toward link
	property p_rx_framed;
		rxvalid |-> rxactive && phy_dq_oe;
	endproperty
	a_rx_framed: assert property (p_rx_framed)
		else $error("rxvalid outside packet");

	// Receive strobe lasts one cycle
	property p_rx_pulse;
		rxvalid |=> !rxvalid;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse)
		else $error("rxvalid longer than one cycle");
endmodule

// ### tb/tb.sv
// Testbench joining both ends through the interface, with a queue model of bytes.
// Assumes a 100 MHz i_mclk and the shared constants header.
`timescale 1ns/1ns
`include "utmi_consts.svh"
module tb;
	import utmi_pkg::*;
	logic i_mclk, i_resetn, tx_valid, tx_last, tx_taken, rx_sync, rx_load, rx_eop, disc;
	logic tx_dat, tx_se0, tx_oe, host, rx_out_valid, rx_act, hdisc, prev, sync_seen, b;
	logic [7:0] tx_byte, rx_byte, rx_out, sh;
	xcvr_sel_t sel;
	op_mode_t opm;
	int n_mismatch, checks_done, cyc, seed, se0_cyc, ones, nb;
	logic [7:0] tx_q[$];
	logic [7:0] ser_q[$];
	logic [7:0] rx_q[$];
	utmi_if pif();
	utmi_link_end i_utmi_link_end(.i_mclk(i_mclk), .i_resetn(i_resetn), .pif(pif), .i_tx_byte(tx_byte),
		.i_tx_byte_valid(tx_valid), .i_tx_byte_last(tx_last), .o_tx_byte_taken(tx_taken), .i_xcvr_sel(sel),
		.i_op_mode(opm), .i_host_mode(host), .o_rx_byte(rx_out), .o_rx_byte_valid(rx_out_valid),
		.o_rx_active(rx_act), .o_hostdisc(hdisc));
	utmi_phy_end i_utmi_phy_end(.i_mclk(i_mclk), .i_resetn(i_resetn), .pif(pif), .i_rx_sync_det(rx_sync),
		.i_rx_byte(rx_byte), .i_rx_byte_load(rx_load), .i_rx_eop_det(rx_eop), .i_disc_comp(disc),
		.o_tx_dat(tx_dat), .o_tx_se0(tx_se0), .o_tx_oe(tx_oe));
	utmi_monitor i_utmi_monitor(.i_mclk(i_mclk), .i_resetn(i_resetn), .parallel_if_clock(pif.parallel_if_clock),
		.txvalid(pif.txvalid), .txready(pif.txready), .rxactive(pif.rxactive), .rxvalid(pif.rxvalid),
		.phy_dq_oe(pif.phy_dq_oe), .xcvr_sel(pif.xcvr_sel), .op_mode(pif.op_mode));

	// Clock
	initial
	begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Byte model on the bus, receive model, high speed line decoder and watchdog
	always @(posedge i_mclk)
	begin
		if (pif.txvalid === 1'b1 && pif.txready === 1'b1)
			check(pif.data, tx_q.size() ? tx_q.pop_front() : 8'hxx);
		if (rx_out_valid === 1'b1)
			check(rx_out, rx_q.size() ? rx_q.pop_front() : 8'hxx);
		if (tx_se0 === 1'b1)
			se0_cyc++;
		if (tx_oe !== 1'b1)
		begin
			prev = 1'b1;
			sync_seen = 1'b0;
			ones = 0;
			nb = 0;
		end
		else if (sel == SEL_HS)
		begin
			b = (tx_dat === prev);
			prev = tx_dat;
			if (!b)
				sync_seen = 1'b1;
			if (sync_seen && ones == 6)
			begin
				ones = 0;
				if (ser_q.size())
					check(b, 1'b0);
			end
			else if (sync_seen)
			begin
				ones = b ? ones + 1 : 0;
				sh = {b, sh[7:1]};
				nb++;
				if (nb == 8 && ser_q.size())
					check(sh, ser_q.pop_front());
				if (nb == 8)
					nb = 0;
			end
		end
		cyc++;
		if (cyc > 60000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	// Send one packet through the link user side and wait out the gap
	task automatic send(input xcvr_sel_t s, input int n, input logic [7:0] pid);
		logic [7:0] v;
		int k;
		sel <= s;
		repeat (3) @(posedge i_mclk);
		se0_cyc = 0;
		if (s == SEL_HS)
			ser_q.push_back(`SYNC_BYTE);
		for (int i = 0; i < n; i++)
		begin
			v = (i == 0) ? pid : ((i == 2) ? 8'hff : 8'($random(seed)));
			tx_q.push_back(v);
			if (s == SEL_HS)
				ser_q.push_back(v);
			tx_byte <= v;
			tx_valid <= 1'b1;
			tx_last <= (i == n - 1);
			k = 0;
			do begin @(posedge i_mclk); k++; end while (tx_taken !== 1'b1 && k < 3000);
		end
		tx_valid <= 1'b0;
		k = 0;
		// Keep-alive leaves the line undriven until its end, so wait for that end as well
		do begin @(posedge i_mclk); k++; end while ((pif.txvalid !== 1'b0 || tx_oe !== 1'b0 ||
			(s != SEL_HS && se0_cyc == 0)) && k < 5000);
		repeat (`IPG_CYC + 4) @(posedge i_mclk);
		check(8'(tx_q.size()), 8'h00);
		check(8'(ser_q.size()), 8'h00);
		if (s == SEL_FS)
			check(8'(se0_cyc), 8'(`FS_EOP_SE0_BITS * `FS_BIT_CYC));
		if (s == SEL_LS)
			check(8'(se0_cyc), 8'(`FS_EOP_SE0_BITS * `LS_BIT_CYC));
	endtask

	// One refused load, then a framed packet of n random bytes
	task automatic recv(input int n);
		logic [7:0] v;
		@(posedge i_mclk) rx_load <= 1'b1;
		@(posedge i_mclk) rx_load <= 1'b0;
		rx_sync <= 1'b1;
		@(posedge i_mclk) rx_sync <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			repeat (4) @(posedge i_mclk);
			v = 8'($random(seed));
			rx_q.push_back(v);
			rx_byte <= v;
			rx_load <= 1'b1;
			@(posedge i_mclk) rx_load <= 1'b0;
			check(rx_act, 1'b1);
		end
		repeat (4) @(posedge i_mclk);
		rx_eop <= 1'b1;
		@(posedge i_mclk) rx_eop <= 1'b0;
		repeat (4) @(posedge i_mclk);
		check(rx_act, 1'b0);
		check(8'(rx_q.size()), 8'h00);
	endtask

	// Main sequence
	initial
	begin
		seed = 32'h3f216168;
		i_resetn = 1'b0;
		{tx_valid, tx_last, rx_sync, rx_load, rx_eop, disc, host} = 7'h00;
		tx_byte = 8'h00;
		rx_byte = 8'h5a;
		sel = SEL_FS;
		opm = OP_NORMAL;
		repeat (4) @(posedge i_mclk);
		i_resetn <= 1'b1;
		recv(5);
		send(SEL_HS, 5, 8'hc3);
		send(SEL_FS, 4, 8'hc3);
		send(SEL_LS, 3, 8'h4b);
		send(SEL_FS_PRE, 3, 8'hc3);
		host <= 1'b1;
		disc <= 1'b1;
		send(SEL_HS, 3, `PID_SOF);
		check(hdisc, 1'b1);
		disc <= 1'b0;
		send(SEL_HS, 3, `PID_SOF);
		check(hdisc, 1'b0);
		disc <= 1'b1;
		send(SEL_HS, 3, 8'h69);
		check(hdisc, 1'b0);
		send(SEL_LS, 3, `PID_SOF);
		recv(3);
		// Host resume: K while valid stands, then two LS bits of SE0 and one FS J
		opm <= OP_NOSTUFF;
		repeat (3) @(posedge i_mclk);
		se0_cyc = 0;
		tx_byte <= 8'h00;
		tx_last <= 1'b0;
		tx_valid <= 1'b1;
		repeat (200) @(posedge i_mclk);
		check(tx_oe, 1'b1);
		tx_valid <= 1'b0;
		repeat (300) @(posedge i_mclk);
		check(8'(se0_cyc), 8'(`RESUME_SE0_BITS * `LS_BIT_CYC));
		check(tx_oe, 1'b0);
		opm <= OP_NORMAL;
		end_sim();
	end
endmodule
